// ### hw/tssr_top.sv
`timescale 1ns/1ns
module tssr_top #(
	parameter logic        HIGH_ACCURACY      = 1'b0,
	parameter logic [15:0] MAKER_CODE         = 16'h5a5a, // arbitrary value
	parameter logic [15:0] PART_REVISION_CODE = 16'h0c30, // arbitrary value
	parameter int          TIMEOUT_CYC        = tssr_pkg::TIMEOUT_CYC,
	parameter int          REFRESH_CYC        = tssr_pkg::REFRESH_CYC
) (
	input  wire logic                   MCLK,
	input  wire logic                   RST_N,
	input  wire logic                   SCL,
	input  wire logic                   SDA_IN,
	output logic                        SDA_OUT,
	output logic                        SDA_OE_N,
	input  wire logic                   SLAVE_SELECT_LOW,
	input  wire logic                   SLAVE_SELECT_MID,
	input  wire logic                   SLAVE_SELECT_HIGH,
	input  wire logic [15:0]            TEMP_DATA,
	input  wire logic                   TEMP_DONE,
	output logic                        MEAS_REQ,
	output logic [15:0]                 SETUP,
	output tssr_pkg::tssr_limits_t      LIMITS
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [4:0]            pin_level;
	logic [4:0]            pin_rise;
	logic [4:0]            pin_fall;
	logic                  scl;
	logic                  sda;
	logic                  scl_rise;
	logic                  scl_fall;
	logic [2:0]            strap;
	logic                  start_cond;
	logic                  stop_cond;

	tssr_pkg::tssr_state_t state;
	logic [3:0]            bit_cnt;
	logic [7:0]            rx;
	logic [7:0]            tx;
	logic                  rw;
	logic                  byte_sel;
	logic [2:0]            index;
	logic [7:0]            hi_byte;
	logic                  wr_en;
	logic                  pend_low;
	logic                  pend_go;
	logic                  read_end;
	logic [15:0]           rd_word;
	logic [7:0]            next_tx_byte;

	logic [15:0]           rw_regs [0:3];
	logic [15:0]           thermal_reading;
	logic [3:0]            hold_cnt;
	logic [tssr_pkg::CNT_W-1:0] to_cnt;
	logic [tssr_pkg::CNT_W-1:0] meas_cnt;
	logic                  timeout_hit;
	logic [2:0]            wr_slot;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	tssr_sync_edge #(
		.W(5)
	) u_sync (
		.clk  (MCLK),
		.rst_n(RST_N),
		.raw  ({SLAVE_SELECT_HIGH, SLAVE_SELECT_MID, SLAVE_SELECT_LOW, SDA_IN, SCL}),
		.level(pin_level),
		.rise (pin_rise),
		.fall (pin_fall)
	);

	// bus conditions decoded from the settled pins
	assign scl        = pin_level[0];
	assign sda        = pin_level[1];
	assign scl_rise   = pin_rise[0];
	assign scl_fall   = pin_fall[0];
	assign strap      = pin_level[4:2];
	assign start_cond = pin_fall[1] & scl;
	assign stop_cond  = pin_rise[1] & scl;

	////////////////////////////////////////////////////////////////////////////
	// read data selection
	always_comb begin
		case (index)
			tssr_pkg::IDX_FEATURE_SUMMARY: begin
				rd_word = HIGH_ACCURACY ? tssr_pkg::FEATURE_HIGH : tssr_pkg::FEATURE_STD;
			end
			tssr_pkg::IDX_SETUP_CONTROL:      rd_word = rw_regs[0];
			tssr_pkg::IDX_ALARM_HIGH_LIMIT:   rd_word = rw_regs[1];
			tssr_pkg::IDX_ALARM_LOW_LIMIT:    rd_word = rw_regs[2];
			tssr_pkg::IDX_OVERHEAT_LIMIT:     rd_word = rw_regs[3];
			tssr_pkg::IDX_THERMAL_READING:    rd_word = thermal_reading;
			tssr_pkg::IDX_MAKER_CODE:         rd_word = MAKER_CODE;
			tssr_pkg::IDX_PART_REVISION_CODE: rd_word = PART_REVISION_CODE;
			default:                          rd_word = 16'h0000;
		endcase
	end

	// byte sent after a master ack: the other half of the word
	assign next_tx_byte = byte_sel ? rd_word[15:8] : rd_word[7:0];

	////////////////////////////////////////////////////////////////////////////
	// protocol state machine
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state    <= tssr_pkg::ST_IDLE;
			bit_cnt  <= 4'h0;
			rx       <= 8'h00;
			tx       <= 8'h00;
			rw       <= 1'b0;
			byte_sel <= 1'b0;
			index    <= tssr_pkg::INDEX_RESET;
			hi_byte  <= 8'h00;
			wr_en    <= 1'b0;
			pend_low <= 1'b0;
			pend_go  <= 1'b0;
			read_end <= 1'b0;
		end else begin
			wr_en    <= 1'b0;
			pend_go  <= 1'b0;
			read_end <= 1'b0;
			if (timeout_hit) begin
				// abandon stalled transfer, let go of the line
				state    <= tssr_pkg::ST_IDLE;
				pend_low <= 1'b0;
				pend_go  <= 1'b1;
			end else if (start_cond) begin
				// start or repeated start
				state    <= tssr_pkg::ST_ADDR;
				bit_cnt  <= 4'h0;
				pend_low <= 1'b0;
				pend_go  <= 1'b1;
			end else if (stop_cond) begin
				state    <= tssr_pkg::ST_IDLE;
				pend_low <= 1'b0;
				pend_go  <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					tssr_pkg::ST_ADDR, tssr_pkg::ST_INDEX, tssr_pkg::ST_WDATA: begin
						rx      <= {rx[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end
					tssr_pkg::ST_RDATA: begin
						bit_cnt <= bit_cnt + 4'h1;
					end
					tssr_pkg::ST_RACK: begin
						if (sda) begin
							// nack: transfer over
							state    <= tssr_pkg::ST_IDLE;
							read_end <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					tssr_pkg::ST_ADDR: begin
						if (bit_cnt == tssr_pkg::BITS_PER_BYTE) begin
							pend_go <= 1'b1;
							if (rx[7:1] == {tssr_pkg::DEVICE_TYPE_CODE, strap}) begin
								state    <= tssr_pkg::ST_ADDR_ACK;
								rw       <= rx[0];
								pend_low <= 1'b1;
							end else begin
								state <= tssr_pkg::ST_IDLE;
							end
						end
					end
					tssr_pkg::ST_ADDR_ACK: begin
						bit_cnt  <= 4'h0;
						byte_sel <= 1'b0;
						pend_go  <= 1'b1;
						if (rw) begin
							// read straight from the held index
							state    <= tssr_pkg::ST_RDATA;
							tx       <= rd_word[15:8];
							pend_low <= ~rd_word[15];
						end else begin
							state    <= tssr_pkg::ST_INDEX;
							pend_low <= 1'b0;
						end
					end
					tssr_pkg::ST_INDEX: begin
						if (bit_cnt == tssr_pkg::BITS_PER_BYTE) begin
							index    <= rx[2:0];
							state    <= tssr_pkg::ST_INDEX_ACK;
							pend_low <= 1'b1;
							pend_go  <= 1'b1;
						end
					end
					tssr_pkg::ST_INDEX_ACK: begin
						state    <= tssr_pkg::ST_WDATA;
						bit_cnt  <= 4'h0;
						byte_sel <= 1'b0;
						pend_low <= 1'b0;
						pend_go  <= 1'b1;
					end
					tssr_pkg::ST_WDATA: begin
						if (bit_cnt == tssr_pkg::BITS_PER_BYTE) begin
							// high byte first, commit on the low byte
							if (!byte_sel) begin
								hi_byte <= rx;
							end else begin
								wr_en <= 1'b1;
							end
							state    <= tssr_pkg::ST_WDATA_ACK;
							pend_low <= 1'b1;
							pend_go  <= 1'b1;
						end
					end
					tssr_pkg::ST_WDATA_ACK: begin
						state    <= tssr_pkg::ST_WDATA;
						bit_cnt  <= 4'h0;
						byte_sel <= ~byte_sel;
						pend_low <= 1'b0;
						pend_go  <= 1'b1;
					end
					tssr_pkg::ST_RDATA: begin
						pend_go <= 1'b1;
						if (bit_cnt == tssr_pkg::BITS_PER_BYTE) begin
							state    <= tssr_pkg::ST_RACK;
							pend_low <= 1'b0;
						end else begin
							tx       <= {tx[6:0], 1'b0};
							pend_low <= ~tx[6];
						end
					end
					tssr_pkg::ST_RACK: begin
						// master acked: send the other byte
						state    <= tssr_pkg::ST_RDATA;
						bit_cnt  <= 4'h0;
						byte_sel <= ~byte_sel;
						tx       <= next_tx_byte;
						pend_low <= ~next_tx_byte[7];
						pend_go  <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sda driver, changes only after the data hold time
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			hold_cnt <= 4'h0;
			SDA_OUT  <= 1'b1;
			SDA_OE_N <= 1'b1;
		end else if (pend_go) begin
			hold_cnt <= tssr_pkg::HOLD_CYC;
		end else if (hold_cnt != 4'h0) begin
			hold_cnt <= hold_cnt - 4'h1;
			if (hold_cnt == 4'h1) begin
				SDA_OUT  <= ~pend_low;
				SDA_OE_N <= ~pend_low; // low while pulling the line
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// writable registers
	assign wr_slot = index - 3'h1;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int k = 0; k < 4; k++) begin
				rw_regs[k] <= tssr_pkg::RW_RESET;
			end
		end else if (wr_en && index >= tssr_pkg::IDX_SETUP_CONTROL
				&& index <= tssr_pkg::IDX_OVERHEAT_LIMIT) begin
			// read-only targets fall outside this window
			rw_regs[wr_slot[1:0]] <= {hi_byte, rx};
		end
	end

	// configuration and limits out to the comparator logic
	assign SETUP       = rw_regs[0];
	assign LIMITS.high = rw_regs[1];
	assign LIMITS.low  = rw_regs[2];
	assign LIMITS.crit = rw_regs[3];

	////////////////////////////////////////////////////////////////////////////
	// latched temperature, readable at any time
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			thermal_reading <= tssr_pkg::READING_RESET;
		end else if (TEMP_DONE) begin
			thermal_reading <= TEMP_DATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus timeout: counts while scl is held low inside a transfer
	assign timeout_hit = (to_cnt == tssr_pkg::CNT_W'(TIMEOUT_CYC));

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			to_cnt <= '0;
		end else if (state == tssr_pkg::ST_IDLE || scl || timeout_hit) begin
			to_cnt <= '0;
		end else begin
			to_cnt <= to_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion requests: periodic, and restarted after a finished read
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			meas_cnt <= '0;
			MEAS_REQ <= 1'b0;
		end else if (rw_regs[0][tssr_pkg::SHUTDOWN_BIT]) begin
			// shutdown stops sampling, bus stays live
			meas_cnt <= '0;
			MEAS_REQ <= 1'b0;
		end else if ((read_end && !MEAS_REQ)
				|| meas_cnt == tssr_pkg::CNT_W'(REFRESH_CYC - 1)) begin
			// a read ending right after a periodic request reuses that conversion
			meas_cnt <= '0;
			MEAS_REQ <= 1'b1;
		end else begin
			meas_cnt <= meas_cnt + 1'b1;
			MEAS_REQ <= 1'b0;
		end
	end

endmodule

// ### hw/tssr_pkg.sv
package tssr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_KHZ     = 25000;
	localparam int CLK_NS      = 40;
	localparam int HOLD_NS     = 300;
	localparam int TIMEOUT_MS  = 35;
	localparam int REFRESH_MS  = 125;
	// least hold time, rounded up to whole cycles
	localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	localparam int REFRESH_CYC = REFRESH_MS * CLK_KHZ;
	localparam int CNT_W       = 22;

	////////////////////////////////////////////////////////////////////////////
	// addressing
	localparam logic [3:0] DEVICE_TYPE_CODE = 4'h3;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
	localparam logic [2:0] INDEX_RESET      = 3'h0;

	// register indices
	localparam logic [2:0] IDX_FEATURE_SUMMARY    = 3'h0;
	localparam logic [2:0] IDX_SETUP_CONTROL      = 3'h1;
	localparam logic [2:0] IDX_ALARM_HIGH_LIMIT   = 3'h2;
	localparam logic [2:0] IDX_ALARM_LOW_LIMIT    = 3'h3;
	localparam logic [2:0] IDX_OVERHEAT_LIMIT     = 3'h4;
	localparam logic [2:0] IDX_THERMAL_READING    = 3'h5;
	localparam logic [2:0] IDX_MAKER_CODE         = 3'h6;
	localparam logic [2:0] IDX_PART_REVISION_CODE = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// reset values and fields
	localparam logic [15:0] FEATURE_STD   = 16'h002d;
	localparam logic [15:0] FEATURE_HIGH  = 16'h002f;
	localparam logic [15:0] RW_RESET      = 16'h0000;
	localparam logic [15:0] READING_RESET = 16'h0000;
	localparam int          SHUTDOWN_BIT  = 8;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_INDEX     = 4'h3,
		ST_INDEX_ACK = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RACK      = 4'h8
	} tssr_state_t;

	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
		logic [15:0] crit;
	} tssr_limits_t;

endpackage

// ### hw/tssr_sync_edge.sv
`timescale 1ns/1ns
module tssr_sync_edge #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] meta;
	logic [W-1:0] prev;

	////////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser plus one history flop per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					meta[i]  <= 1'b1;
					level[i] <= 1'b1;
					prev[i]  <= 1'b1;
				end else begin
					meta[i]  <= raw[i];
					level[i] <= meta[i];
					prev[i]  <= level[i];
				end
			end
			// edges seen only on the settled stages
			assign rise[i] = level[i] & ~prev[i];
			assign fall[i] = ~level[i] & prev[i];
		end
	endgenerate

endmodule

// ### testbench/tssr_monitor.sv
`timescale 1ns/1ns
module tssr_monitor #(
	parameter int TIMEOUT_CYC = 200,
	parameter int REFRESH_CYC = 300
) (
	input wire logic                   MCLK,
	input wire logic                   RST_N,
	input wire logic                   SCL,
	input wire logic                   SDA_OE_N,
	input wire logic                   MEAS_REQ,
	input wire logic [15:0]            SETUP,
	input wire tssr_pkg::tssr_limits_t LIMITS
);
	int low_cnt;
	int idle_cnt;

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////////////
	// cycles the serial clock has been held low
	always_ff @(posedge MCLK) begin
		if (!RST_N || SCL) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end

	// cycles since the last conversion request while running
	always_ff @(posedge MCLK) begin
		if (!RST_N || MEAS_REQ || SETUP[8]) begin
			idle_cnt <= 0;
		end else begin
			idle_cnt <= idle_cnt + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// properties
	reset_values_a: assert property ($rose(RST_N) |-> SDA_OE_N && !MEAS_REQ
		&& SETUP == 16'h0000 && LIMITS == '0) else $error("bad values after reset");
	meas_pulse_a: assert property (MEAS_REQ |=> !MEAS_REQ)
		else $error("conversion request longer than one cycle");
	shutdown_quiet_a: assert property ($past(SETUP[8]) && SETUP[8] |-> !MEAS_REQ)
		else $error("conversion requested in shutdown");
	sda_hold_a: assert property ($changed(SDA_OE_N) |-> !SCL && !$past(SCL))
		else $error("data line moved while clock high");
	setup_stable_a: assert property ($changed(SETUP) |-> !SCL)
		else $error("setup changed outside a byte boundary");
	limits_stable_a: assert property ($changed(LIMITS) |-> !SCL)
		else $error("limits changed outside a byte boundary");
	bus_timeout_a: assert property (low_cnt == TIMEOUT_CYC + 24 |-> SDA_OE_N)
		else $error("data line held after bus timeout");
	refresh_period_a: assert property (idle_cnt <= REFRESH_CYC + 4)
		else $error("reading not refreshed in time");
endmodule

// ### testbench/tssr_host_model.sv
`timescale 1ns/1ns
module tssr_host_model #(
	parameter int Q = 17
) (
	input wire logic clk,
	input wire logic sda,
	output logic     scl,
	output logic     sda_low
);
	// bus starts released with the clock high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// timing helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one clock of 4*Q cycles, data set Q after the fall, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		tick(Q);
		sda_low <= !b;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		r = sda;
		tick(Q);
	endtask

	// start or repeated start
	task automatic start();
		scl <= 1'b0;
		tick(Q);
		sda_low <= 1'b0;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sda_low <= 1'b1;
		tick(Q);
	endtask

	// stop leaves both lines high
	task automatic stop();
		scl <= 1'b0;
		tick(Q);
		sda_low <= 1'b1;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sda_low <= 1'b0;
		tick(Q);
	endtask

	// byte out msb first, then the slave's ack
	task automatic wbyte(input logic [7:0] w, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask

	// byte in msb first, nack on the last one
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask

	// clock held low
	task automatic stall(input int n);
		scl <= 1'b0;
		tick(n);
	endtask
endmodule

// ### testbench/tssr_top_tb.sv
`timescale 1ns/1ns
module tssr_top_tb;
	localparam int TO_CYC = 200;
	localparam int RF_CYC = 300;
	logic                   mclk, rst_n, temp_done, conv_en, sda, a;
	logic                   sda_out, sda_oe_n, meas_req, scl, sda_low;
	logic [2:0]             strap;
	logic [2:0]             ro [4];
	logic [15:0]            temp_data, conv_val, setup, d, v;
	logic [15:0]            shadow [8];
	tssr_pkg::tssr_limits_t limits;
	int                     errors, n_tests, seed, cyc, last_req;

	// open-drain data line with pull-up
	assign sda = !sda_low && sda_oe_n;

	// clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	tssr_top #(.TIMEOUT_CYC(TO_CYC), .REFRESH_CYC(RF_CYC)) dut (
		.MCLK(mclk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .SLAVE_SELECT_LOW(strap[0]), .SLAVE_SELECT_MID(strap[1]),
		.SLAVE_SELECT_HIGH(strap[2]), .TEMP_DATA(temp_data), .TEMP_DONE(temp_done),
		.MEAS_REQ(meas_req), .SETUP(setup), .LIMITS(limits));

	tssr_host_model host (.clk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

	////////////////////////////////////////////////////////////////////////////
	// converter stand-in and request tracker
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		temp_done <= 1'b0;
		if (meas_req) last_req <= cyc;
		if (meas_req && conv_en) begin
			temp_done <= 1'b1;
			temp_data <= conv_val;
			shadow[5] <= conv_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// compare, expectation and bus helpers
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] addr_b(input logic rd);
		return {4'h3, strap, rd};
	endfunction

	function automatic logic [15:0] port_val(input logic [2:0] idx);
		case (idx)
			3'h1: return setup;
			3'h2: return limits.high;
			3'h3: return limits.low;
			default: return limits.crit;
		endcase
	endfunction

	task automatic wr_reg(input logic [2:0] idx, input logic [15:0] w);
		logic k;
		host.start();
		host.wbyte(addr_b(1'b0), k);
		chk1(k, 1'b1);
		host.wbyte({5'h00, idx}, k);
		host.wbyte(w[15:8], k);
		host.wbyte(w[7:0], k);
		host.stop();
		if (idx inside {3'h1, 3'h2, 3'h3, 3'h4}) shadow[idx] = w;
	endtask

	task automatic rd_reg(input logic set, input logic [2:0] idx, output logic [15:0] r);
		logic k;
		host.start();
		if (set) begin
			host.wbyte(addr_b(1'b0), k);
			host.wbyte({5'h00, idx}, k);
			host.start();
		end
		host.wbyte(addr_b(1'b1), k);
		host.rbyte(1'b0, r[15:8]);
		host.rbyte(1'b1, r[7:0]);
		host.stop();
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'h7f11;
		{errors, n_tests, cyc} = '0;
		last_req = -1000;
		{rst_n, conv_en, temp_done} = '0;
		temp_data = 16'h0000;
		strap = 3'($random(seed));
		conv_val = 16'($random(seed));
		shadow = '{16'h002d, 0, 0, 0, 0, 0, 16'h5a5a, 16'h0c30}; // codes arbitrary
		ro = '{3'h0, 3'h5, 3'h6, 3'h7};
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		rd_reg(1'b0, 3'h0, d);
		chk16(d, shadow[0]);
		$display("power-up read done");
		host.start();
		host.wbyte(addr_b(1'b1), a);
		host.stall(40);
		chk1(sda, 1'b0);
		chk1(sda_out, 1'b0);
		host.stall(TO_CYC + 60);
		chk1(sda, 1'b1);
		chk1(sda_out, 1'b1);
		host.stop();
		$display("bus timeout done");
		conv_en <= 1'b1;
		rd_reg(1'b0, 3'h0, d);
		chk1(cyc - last_req < 150, 1'b1);
		conv_en <= 1'b0;
		rd_reg(1'b1, 3'h5, d);
		chk16(d, shadow[5]);
		$display("measurement read done");
		foreach (ro[k]) begin
			host.start();
			host.wbyte(k[0] ? {4'ha, strap, 1'b0} : {4'h3, strap ^ 3'h1, 1'b0}, a);
			chk1(a, 1'b0);
			host.stop();
		end
		$display("address decode done");
		for (int i = 1; i <= 4; i++) begin
			v = 16'($random(seed));
			wr_reg(3'(i), v);
			chk16(port_val(3'(i)), v);
			rd_reg(1'b1, 3'(i), d);
			chk16(d, v);
		end
		$display("read/write registers done");
		foreach (ro[k]) begin
			wr_reg(ro[k], 16'($random(seed)));
			rd_reg(1'b0, ro[k], d);
			chk16(d, shadow[ro[k]]);
		end
		$display("read-only registers done");
		report_and_stop();
	end
endmodule

bind tssr_top tssr_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .REFRESH_CYC(REFRESH_CYC)) mon (
	.MCLK(MCLK), .RST_N(RST_N), .SCL(SCL), .SDA_OE_N(SDA_OE_N),
	.MEAS_REQ(MEAS_REQ), .SETUP(SETUP), .LIMITS(LIMITS));
